/* File: byte_ram.v */
// Small synchronous RAM with registered read data, holds image bytes.
`timescale 1ns/1ps
module byte_ram (
	input  wire       clk_sys_i,
	input  wire       we_i,
	input  wire [7:0] waddr_i,
	input  wire [7:0] wdata_i,
	input  wire [7:0] raddr_i,
	output reg  [7:0] rdata_o
);
	reg [7:0] mem [0:255];

	// Write port and registered read port.
	always @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // byte_ram

/* File: fieldbus_ctl.sv */
// Controller side model that collects the framed input stream.
`timescale 1ns/1ps
module fieldbus_ctl (
	input wire       clk_sys_i,
	input wire       valid_i,
	input wire [7:0] byte_i,
	input wire [2:0] port_i,
	input wire       last_i
);
	reg [11:0] rx [$];
	// Keeps each byte with its port and end mark; bit 3 of a closing byte is
	// never evaluated, so it is cleared here.
	always @(posedge clk_sys_i)
		if (valid_i)
			rx.push_back({last_i, port_i, byte_i & {4'hF, ~last_i, 3'h7}});
endmodule // fieldbus_ctl

/* File: framer_monitor.sv */
// Port checks of the port process data framer.
`timescale 1ns/1ps
module framer_monitor (
	input wire        clk_sys_i,
	input wire        resetn_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire [11:0] paddr_i,
	input wire        pready_o,
	input wire        pslverr_o,
	input wire        in_valid_o,
	input wire [7:0]  in_byte_o,
	input wire [2:0]  in_port_o,
	input wire        in_last_o,
	input wire        exch_done_o
);
	reg [2:0] pport_r;
	reg       plast_r;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Port and end mark of the latest byte; reset looks like port 7 closed.
	always @(posedge clk_sys_i or negedge resetn_i)
		if (!resetn_i) begin
			pport_r <= 3'h7;
			plast_r <= 1'b1;
		end else if (in_valid_o) begin
			pport_r <= in_port_o;
			plast_r <= in_last_o;
		end
	a_ready_zero: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready late");
	a_ready_once: assert property (pready_o |-> penable_i && !$past(penable_i))
		else $error("pready outside first access cycle");
	a_err_map: assert property (psel_i && penable_i && pready_o &&
		paddr_i > 12'h034 |-> pslverr_o) else $error("unmapped accepted");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	a_qual_rsv: assert property (in_valid_o && in_last_o |->
		!in_byte_o[3] && !in_byte_o[1]) else $error("reserved bit set");
	a_port_order: assert property (in_valid_o |-> (plast_r ?
		in_port_o == pport_r + 3'h1 : in_port_o == pport_r))
		else $error("port order broken");
	a_byte_gap: assert property (in_valid_o |=> !in_valid_o)
		else $error("bytes too close");
	a_done_last: assert property (exch_done_o |->
		(in_valid_o ? in_last_o : plast_r) &&
		(in_valid_o ? in_port_o : pport_r) == 3'h7)
		else $error("done before port 7 closed");
	a_done_once: assert property (exch_done_o |=> !exch_done_o)
		else $error("done longer than a pulse");
	c_qual: cover property (in_valid_o && in_last_o);
	c_done: cover property (exch_done_o);
	c_err: cover property (pslverr_o);
endmodule // framer_monitor
bind port_process_data_framer framer_monitor framer_monitor_i (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
	.penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .in_valid_o(in_valid_o),
	.in_byte_o(in_byte_o), .in_port_o(in_port_o),
	.in_last_o(in_last_o), .exch_done_o(exch_done_o));

/* File: framer_regs.vh */
// Constants of the port process data framer: offsets, fields, resets, codes.
`ifndef FRAMER_REGS_VH
`define FRAMER_REGS_VH
// ----------------------------------------------------------------------------
// Register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------------------
`define OFS_PORT_CFG      12'h000
`define OFS_PORT_ENABLE   12'h020
`define OFS_OUT_SRC       12'h024
`define OFS_IRQ_STATUS    12'h028
`define OFS_IRQ_MASK      12'h02C
`define OFS_PORT_STATE    12'h030
`define OFS_IMG_LEN       12'h034
`define OFS_STRIDE        12'h004
`define NUM_PORTS         4'h8
// ----------------------------------------------------------------------------
// Port configuration word fields
// ----------------------------------------------------------------------------
`define CFG_MODE_LO       0
`define CFG_MODE_HI       1
`define CFG_IN_LO         8
`define CFG_IN_HI         13
`define CFG_OUT_LO        16
`define CFG_OUT_HI        21
`define MODE_COM          2'h0
`define MODE_DI           2'h1
`define MODE_DO           2'h2
`define LEN_MIN           6'h01
`define IN_LEN_MAX        6'h21
`define OUT_LEN_MAX       6'h20
`define LEN_ONE           6'h01
`define CFG_RESET         32'h0001_0100
// ----------------------------------------------------------------------------
// Qualifier byte bit positions
// ----------------------------------------------------------------------------
`define Q_RSV0            0
`define Q_RSV1            1
`define Q_PARAM           2
`define Q_SUBST           3
`define Q_ENABLED         4
`define Q_LINK            5
`define Q_FAULT           6
`define Q_VALID           7
`define PORT_EN_RESET     8'hFF
`define IRQ_MASK_RESET    8'h00
`endif

/* File: port_process_data_framer.v */
// Top of the port process data framer with its APB register slave.
// What this block does
// - Each port takes an input image of 1 to 33 bytes and an output image of 1 to 32 bytes in communication mode.
// - The eight ports are framed in port order as sub-slots 1.2 to 1.9, each with its own lengths.
// - In communication mode the qualifier byte is appended after the device input bytes.
// - A digital-input port has a one-byte image with the input in bit 0 and no qualifier.
// - The port image layout does not depend on the status/control bit mapping mode.
// - Qualifier bits 0 and 1 are zero and bit 3 is unsupported and not to be evaluated.
// - Qualifier bit 2 is set once changed parameters were uploaded and a new backup object exists.
// - Qualifier bit 4 is one while the port is activated and zero once deactivated.
// - Qualifier bit 5 is one while a device is in PREOPERATE or OPERATE.
// - Qualifier bit 6 is one when an error or warning is tied to the device or port.
// - Qualifier bit 7 is one only while device input data is valid.
// - A digital-output port has a one-byte output image whose bit 0 drives channel A.
// - With the status/control module as source, output byte bit 0 is ignored.
`timescale 1ns/1ps
`include "framer_regs.vh"
module port_process_data_framer (
	input  wire        clk_sys_i,
	input  wire        resetn_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	output reg         irq_o,
	input  wire [7:0]  param_changed_flag_i,
	input  wire [7:0]  device_link_up_flag_i,
	input  wire [7:0]  port_fault_flag_i,
	input  wire [7:0]  input_data_valid_flag_i,
	input  wire [7:0]  di_state_i,
	input  wire [7:0]  sc_do_state_i,
	input  wire        dev_we_i,
	input  wire [2:0]  dev_port_i,
	input  wire [4:0]  dev_idx_i,
	input  wire [7:0]  dev_byte_i,
	input  wire        exch_start_i,
	output reg         in_valid_o,
	output reg  [7:0]  in_byte_o,
	output reg  [2:0]  in_port_o,
	output reg         in_last_o,
	input  wire        out_we_i,
	input  wire [2:0]  out_port_i,
	input  wire [4:0]  out_idx_i,
	input  wire [7:0]  out_byte_i,
	output reg  [7:0]  chan_a_do_o,
	output reg         exch_done_o
);
	// ------------------------------------------------------------------------
	// Functions and state
	// ------------------------------------------------------------------------
	localparam S_IDLE = 3'b001;
	localparam S_RD   = 3'b010;
	localparam S_OUT  = 3'b100;

	// Input image length of a port from its mode and configured length.
	function [5:0] in_len;
		input [31:0] cfg;
		begin
			if (cfg[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_COM)
				in_len = cfg[`CFG_IN_HI:`CFG_IN_LO];
			else
				in_len = `LEN_ONE;
		end
	endfunction

	// Clamp a written length into the legal range.
	function [5:0] clamp;
		input [5:0] v;
		input [5:0] mx;
		begin
			if (v < `LEN_MIN)
				clamp = `LEN_MIN;
			else if (v > mx)
				clamp = mx;
			else
				clamp = v;
		end
	endfunction

	reg  [31:0] cfg_r [0:7];
	reg  [7:0]  port_en_r;
	reg  [7:0]  out_src_r;
	reg  [7:0]  irq_stat_r;
	reg  [7:0]  irq_mask_r;
	reg  [7:0]  link_d_r;
	reg  [7:0]  fault_d_r;
	reg  [2:0]  state_r;
	reg  [2:0]  port_r;
	reg  [5:0]  idx_r;
	reg  [5:0]  len_r;
	reg  [7:0]  qual_r;
	reg         rd_pend_r;
	reg         rd_last_r;
	reg  [1:0]  rd_kind_r;
	wire [7:0]  ram_rdata;
	wire [7:0]  out_rdata;
	wire [11:0] cfg_sel;
	wire        acc;
	wire        in_cfg_range;
	wire [7:0]  irq_set;
	wire [31:0] cur_cfg;
	integer     i;

	assign acc = psel_i & penable_i;
	assign cfg_sel = paddr_i - `OFS_PORT_CFG;
	assign in_cfg_range = (paddr_i < `OFS_PORT_ENABLE);
	assign irq_set = (device_link_up_flag_i ^ link_d_r)
		| (port_fault_flag_i & ~fault_d_r);
	assign cur_cfg = cfg_r[port_r];

	// ------------------------------------------------------------------------
	// Image memories
	// ------------------------------------------------------------------------
	byte_ram u_in_ram (
		.clk_sys_i (clk_sys_i),
		.we_i      (dev_we_i),
		.waddr_i   ({dev_port_i, dev_idx_i}),
		.wdata_i   (dev_byte_i),
		.raddr_i   ({port_r, idx_r[4:0]}),
		.rdata_o   (ram_rdata)
	);

	byte_ram u_out_ram (
		.clk_sys_i (clk_sys_i),
		.we_i      (out_we_i),
		.waddr_i   ({out_port_i, out_idx_i}),
		.wdata_i   (out_byte_i),
		.raddr_i   ({port_r, 5'h00}),
		.rdata_o   (out_rdata)
	);

	// ------------------------------------------------------------------------
	// APB slave, configuration and interrupt status
	// ------------------------------------------------------------------------
	// Answers in the access cycle; a status read clears only the bits that it
	// reported, so an event landing at the setup edge is not lost; a new
	// event wins over the clear.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < 8; i = i + 1)
				cfg_r[i] <= `CFG_RESET;
			port_en_r  <= `PORT_EN_RESET;
			out_src_r  <= 8'h00;
			irq_stat_r <= 8'h00;
			irq_mask_r <= `IRQ_MASK_RESET;
			link_d_r   <= 8'h00;
			fault_d_r  <= 8'h00;
			prdata_o   <= 32'h0000_0000;
			pready_o   <= 1'b0;
			pslverr_o  <= 1'b0;
			irq_o      <= 1'b0;
		end else begin
			link_d_r  <= device_link_up_flag_i;
			fault_d_r <= port_fault_flag_i;
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			irq_o     <= |(irq_stat_r & irq_mask_r);
			if (psel_i & ~penable_i & ~pwrite_i) begin
				if (in_cfg_range)
					prdata_o <= cfg_r[cfg_sel[4:2]];
				else if (paddr_i == `OFS_PORT_ENABLE)
					prdata_o <= {24'h00_0000, port_en_r};
				else if (paddr_i == `OFS_OUT_SRC)
					prdata_o <= {24'h00_0000, out_src_r};
				else if (paddr_i == `OFS_IRQ_STATUS)
					prdata_o <= {24'h00_0000, irq_stat_r};
				else if (paddr_i == `OFS_IRQ_MASK)
					prdata_o <= {24'h00_0000, irq_mask_r};
				else if (paddr_i == `OFS_PORT_STATE)
					prdata_o <= {device_link_up_flag_i,
						port_fault_flag_i, input_data_valid_flag_i,
						port_en_r};
				else if (paddr_i == `OFS_IMG_LEN)
					prdata_o <= {26'h000_0000, len_r};
				else
					pslverr_o <= 1'b1;
			end
			if (psel_i & ~penable_i & pwrite_i & (paddr_i > `OFS_IMG_LEN))
				pslverr_o <= 1'b1;
			if (acc & pready_o & pwrite_i) begin
				if (in_cfg_range)
					cfg_r[cfg_sel[4:2]] <= {10'h000,
						clamp(pwdata_i[`CFG_OUT_HI:`CFG_OUT_LO],
							`OUT_LEN_MAX),
						2'h0,
						clamp(pwdata_i[`CFG_IN_HI:`CFG_IN_LO],
							`IN_LEN_MAX),
						6'h00, pwdata_i[`CFG_MODE_HI:`CFG_MODE_LO]};
				else if (paddr_i == `OFS_PORT_ENABLE)
					port_en_r <= pwdata_i[7:0];
				else if (paddr_i == `OFS_OUT_SRC)
					out_src_r <= pwdata_i[7:0];
				else if (paddr_i == `OFS_IRQ_MASK)
					irq_mask_r <= pwdata_i[7:0];
			end
			if (acc & pready_o & ~pwrite_i & (paddr_i == `OFS_IRQ_STATUS))
				irq_stat_r <= (irq_stat_r & ~prdata_o[7:0]) | irq_set;
			else
				irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	// ------------------------------------------------------------------------
	// Cyclic exchange: input stream of all ports, then channel A outputs
	// ------------------------------------------------------------------------
	// Walks ports 0..7 in order; memory read latency is one cycle.
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r     <= S_IDLE;
			port_r      <= 3'h0;
			idx_r       <= 6'h00;
			len_r       <= 6'h00;
			qual_r      <= 8'h00;
			rd_pend_r   <= 1'b0;
			rd_last_r   <= 1'b0;
			rd_kind_r   <= 2'h0;
			in_valid_o  <= 1'b0;
			in_byte_o   <= 8'h00;
			in_port_o   <= 3'h0;
			in_last_o   <= 1'b0;
			chan_a_do_o <= 8'h00;
			exch_done_o <= 1'b0;
		end else begin
			in_valid_o  <= 1'b0;
			in_last_o   <= 1'b0;
			exch_done_o <= 1'b0;
			rd_pend_r   <= 1'b0;
			if (rd_pend_r) begin
				in_valid_o <= 1'b1;
				in_port_o  <= port_r;
				in_last_o  <= rd_last_r;
				case (rd_kind_r)
				2'h1: in_byte_o <= {7'h00, di_state_i[port_r]};
				2'h2: in_byte_o <= qual_r;
				default: in_byte_o <= ram_rdata;
				endcase
			end
			case (state_r)
			S_IDLE: begin
				if (exch_start_i) begin
					port_r  <= 3'h0;
					idx_r   <= 6'h00;
					state_r <= S_RD;
				end
			end
			S_RD: begin
				len_r <= in_len(cur_cfg);
				// Qualifier sampled fresh for this exchange.
				qual_r <= 8'h00;
				qual_r[`Q_PARAM]   <= param_changed_flag_i[port_r];
				qual_r[`Q_ENABLED] <= port_en_r[port_r];
				qual_r[`Q_LINK]    <= device_link_up_flag_i[port_r];
				qual_r[`Q_FAULT]   <= port_fault_flag_i[port_r];
				qual_r[`Q_VALID]   <= input_data_valid_flag_i[port_r];
				if (!rd_pend_r) begin
					rd_pend_r <= 1'b1;
					rd_last_r <= (idx_r + 6'h01 == in_len(cur_cfg));
					if (cur_cfg[`CFG_MODE_HI:`CFG_MODE_LO] != `MODE_COM)
						rd_kind_r <= 2'h1;
					else if (idx_r + 6'h01 == in_len(cur_cfg))
						rd_kind_r <= 2'h2;
					else
						rd_kind_r <= 2'h0;
				end else if (idx_r + 6'h01 == in_len(cur_cfg)) begin
					idx_r <= 6'h00;
					if (port_r == 3'h7) begin
						port_r  <= 3'h0;
						state_r <= S_OUT;
					end else begin
						port_r <= port_r + 3'h1;
					end
				end else begin
					idx_r <= idx_r + 6'h01;
				end
			end
			S_OUT: begin
				// Channel A of a DO-mode port follows bit 0 of its first output byte, or sc_do_state_i if its out_src_r bit is set; other ports drive 0.
				// Each port waits one cycle for the registered memory read.
				if (rd_kind_r != 2'h3) begin
					rd_kind_r <= 2'h3;
				end else begin
					rd_kind_r <= 2'h0;
					if (cur_cfg[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_DO)
						chan_a_do_o[port_r] <= out_src_r[port_r]
							? sc_do_state_i[port_r]
							: out_rdata[0];
					else
						chan_a_do_o[port_r] <= 1'b0;
					if (port_r == 3'h7) begin
						state_r     <= S_IDLE;
						exch_done_o <= 1'b1;
					end else begin
						port_r <= port_r + 3'h1;
					end
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // port_process_data_framer

/* File: port_process_data_framer_tb.sv */
// Self-checking testbench of the port process data framer.
`timescale 1ns/1ps
`include "framer_regs.vh"
module port_process_data_framer_tb;
	reg         clk_sys_i = 1'b0, resetn_i = 1'b0;
	reg         psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	reg  [11:0] paddr_i = 12'h000;
	reg  [31:0] pwdata_i = 32'h0, rd;
	reg  [7:0]  pc = 8'h11, lk = 8'h3C, ft = 8'h55, vd = 8'h0F, db = 8'h00;
	reg  [7:0]  di = 8'h02, sc = 8'h00, en = 8'hF7;
	reg         dwe = 1'b0, owe = 1'b0, st = 1'b0, se;
	reg  [2:0]  dp = 3'h0;
	reg  [4:0]  dx = 5'h00;
	wire [31:0] prdata_o;
	wire        pready_o, pslverr_o, irq_o, iv, il, done;
	wire [7:0]  ib, cdo;
	wire [2:0]  ip;
	reg  [1:0]  md [0:7];
	reg  [5:0]  ln [0:7];
	reg  [11:0] eq [$];
	integer     bad_count = 0, samples_checked = 0, cyc = 0, p, i;
	port_process_data_framer port_process_data_framer_i (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irq_o(irq_o), .param_changed_flag_i(pc),
		.device_link_up_flag_i(lk), .port_fault_flag_i(ft),
		.input_data_valid_flag_i(vd), .di_state_i(di), .sc_do_state_i(sc),
		.dev_we_i(dwe), .dev_port_i(dp), .dev_idx_i(dx), .dev_byte_i(db),
		.exch_start_i(st), .in_valid_o(iv), .in_byte_o(ib), .in_port_o(ip),
		.in_last_o(il), .out_we_i(owe), .out_port_i(dp), .out_idx_i(dx),
		.out_byte_i(db), .chan_a_do_o(cdo), .exch_done_o(done));
	fieldbus_ctl fieldbus_ctl_i (.clk_sys_i(clk_sys_i), .valid_i(iv),
		.byte_i(ib), .port_i(ip), .last_i(il));
	// Free running system clock.
	always #5 clk_sys_i = ~clk_sys_i;
	// Cuts a hung run short.
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			end_of_test;
		end
	end
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] s);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("Error %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// One APB transfer; answer taken at the rising edge where pready is high.
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge clk_sys_i);
			psel_i <= 1'b1;
			pwrite_i <= w;
			paddr_i <= a;
			pwdata_i <= d;
			@(posedge clk_sys_i);
			penable_i <= 1'b1;
			do @(posedge clk_sys_i); while (pready_o !== 1'b1);
			rd = prdata_o;
			se = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
		end
	endtask
	// Writes one device input byte, or a controller output byte if o is set.
	task dwr(input o, input [2:0] pt, input [4:0] x, input [7:0] b);
		begin
			@(posedge clk_sys_i);
			dwe <= ~o;
			owe <= o;
			dp <= pt;
			dx <= x;
			db <= b;
			@(posedge clk_sys_i);
			dwe <= 1'b0;
			owe <= 1'b0;
		end
	endtask
	// Runs one exchange and compares the stream with the expected images.
	task exch;
		begin
			fieldbus_ctl_i.rx.delete();
			eq.delete();
			@(posedge clk_sys_i);
			st <= 1'b1;
			for (p = 0; p < 8; p = p + 1)
				if (md[p] != `MODE_COM)
					eq.push_back({1'b1, p[2:0], 7'h00, di[p]});
				else begin
					for (i = 0; i < ln[p] - 1; i = i + 1)
						eq.push_back({1'b0, p[2:0], p[2:0], i[4:0]});
					eq.push_back({1'b1, p[2:0], vd[p], ft[p], lk[p], en[p],
						1'b0, pc[p], 2'h0});
				end
			@(posedge clk_sys_i);
			st <= 1'b0;
			do @(negedge clk_sys_i); while (done !== 1'b1);
			@(negedge clk_sys_i);
			chk("count", eq.size(), fieldbus_ctl_i.rx.size());
			for (i = 0; i < eq.size(); i = i + 1)
				chk("byte", eq[i], fieldbus_ctl_i.rx[i]);
		end
	endtask
	task t_reset;
		begin
			chk("irq", 32'h0, irq_o);
			apb(0, `OFS_PORT_CFG, 32'h0);
			chk("cfg0", `CFG_RESET, rd);
			apb(0, `OFS_PORT_ENABLE, 32'h0);
			chk("enable", `PORT_EN_RESET, rd);
			apb(0, 12'h038, 32'h0);
			chk("slverr", 32'h1, se);
			chk("unmapped", 32'h0, rd);
			apb(1, `OFS_PORT_CFG + `OFS_STRIDE * 12'h007, 32'h003F_0000);
			apb(0, `OFS_PORT_CFG + `OFS_STRIDE * 12'h007, 32'h0);
			chk("clamp", {10'h0, `OUT_LEN_MAX, 2'h0, `LEN_MIN, 6'h0,
				`MODE_COM}, rd);
			$display("reset values done");
		end
	endtask
	task t_frame;
		begin
			for (p = 0; p < 8; p = p + 1) begin
				md[p] = `MODE_COM;
				ln[p] = `LEN_ONE;
				for (i = 0; i < 32; i = i + 1)
					dwr(0, p[2:0], i[4:0], {p[2:0], i[4:0]});
			end
			md[1] = `MODE_DI;
			md[2] = `MODE_DO;
			ln[0] = `IN_LEN_MAX;
			ln[4] = 6'h03;
			for (p = 0; p < 8; p = p + 1)
				apb(1, `OFS_PORT_CFG + `OFS_STRIDE * p[11:0],
					{10'h0, `OUT_LEN_MAX, 2'h0, ln[p], 6'h0, md[p]});
			apb(1, `OFS_PORT_ENABLE, {24'h0, en});
			exch;
			$display("framing done");
		end
	endtask
	task t_refresh;
		begin
			@(posedge clk_sys_i);
			pc <= ~pc;
			lk <= ~lk;
			ft <= ~ft;
			vd <= ~vd;
			di <= ~di;
			en <= 8'h7F;
			apb(1, `OFS_PORT_ENABLE, 32'h7F);
			exch;
			$display("refresh done");
		end
	endtask
	task t_output;
		begin
			dwr(1, 3'h2, 5'h00, 8'h01);
			apb(1, `OFS_OUT_SRC, 32'h0);
			exch;
			chk("chan_a", 32'h04, cdo);
			apb(1, `OFS_OUT_SRC, 32'h04);
			exch;
			chk("chan_a", 32'h0, cdo);
			@(posedge clk_sys_i);
			sc <= 8'h04;
			exch;
			chk("chan_a", 32'h04, cdo);
			$display("output done");
		end
	endtask
	task t_irq;
		begin
			apb(0, `OFS_IRQ_STATUS, 32'h0);
			apb(1, `OFS_IRQ_MASK, 32'h01);
			@(posedge clk_sys_i);
			lk <= lk ^ 8'h01;
			repeat (3) @(negedge clk_sys_i);
			chk("irq", 32'h1, irq_o);
			apb(0, `OFS_IRQ_STATUS, 32'h0);
			chk("status", 32'h01, rd);
			@(posedge clk_sys_i);
			lk <= lk ^ 8'h04;
			repeat (3) @(negedge clk_sys_i);
			chk("irq", 32'h0, irq_o);
			apb(0, `OFS_IRQ_STATUS, 32'h0);
			chk("status", 32'h04, rd);
			$display("interrupt done");
		end
	endtask
	task end_of_test;
		begin
			$display("checked %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Main sequence: reset for three cycles, then the scenarios.
	initial begin
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		t_reset;
		t_frame;
		t_refresh;
		t_output;
		t_irq;
		end_of_test;
	end
endmodule // port_process_data_framer_tb
